// *** rtl/flash_program_margin_protect.sv ***
// flash control sequencer: page program, margin read stretch, block protect, low power
// assumes a synchronous array (data one cycle after array_re) and ordered cpu software
`timescale 1ns/1ns

module flash_program_margin_protect (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// register port
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata_q,
	output logic             rdata_valid_q,
	output logic             hold_q,
	// system state
	input  wire logic        wait_mode,
	input  wire logic        stop_mode,
	input  wire logic        elevated_pin_voltage,
	// flash array and charge pump
	output logic      [15:0] array_addr_q,
	output logic      [7:0]  array_wdata_q,
	output logic             array_we_q,
	output logic             array_re_q,
	output logic             array_margin_q,
	output logic             array_erase_q,
	output logic      [1:0]  array_blk_q,
	output logic             array_standby_q,
	output logic             pump_on_q,
	input  wire logic [7:0]  array_rdata
);

	page_if pg ();

	page_buffer u_page (
		.mclk   (mclk),
		.arst_n (arst_n),
		.pg     (pg)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	flash_pkg::seq_state_type state_q, state_d;
	logic        pgm_q, pgm_d;
	logic        erase_q, erase_d;
	logic        margin_q, margin_d;
	logic        high_voltage_enable_q, high_voltage_enable_d;
	logic [1:0]  blk_q, blk_d;
	logic [1:0]  fdiv_q, fdiv_d;
	logic [7:0]  prot_q, prot_d;
	logic [7:0]  prot_latch_q, prot_latch_d;
	logic        prot_seen_q, prot_seen_d;
	logic        target_ok_q, target_ok_d;
	logic [15:0] target_q, target_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        issue_q, issue_d;
	logic [2:0]  issue_idx_q, issue_idx_d;
	logic [7:0]  rdata_d;
	logic        rdata_valid_d;
	logic        hold_d;
	logic [15:0] array_addr_d;
	logic [7:0]  array_wdata_d;
	logic        array_we_d;
	logic        array_re_d;
	logic        array_margin_d;
	logic        array_erase_d;
	logic        array_standby_d;
	logic        pump_on_d;
	logic        vhi_meta_q;
	logic        vhi_q;

	// ----------------------------------------------------------------
	// elevated pin voltage synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			vhi_meta_q <= 1'b0;
			vhi_q      <= 1'b0;
		end else begin
			vhi_meta_q <= elevated_pin_voltage;
			vhi_q      <= vhi_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// protection check helpers
	// ----------------------------------------------------------------
	logic [7:0] range_mask;
	logic       violation;
	logic       pump_ok;
	logic       ctrl_wr;
	logic       sel_rise;

	// mask of ranges touched by the latched target; erase blocks cover more
	always_comb begin
		range_mask = flash_pkg::RANGE_ONE << target_q[flash_pkg::RANGE_LO +: 3];
		if (erase_q && blk_q == flash_pkg::BLK_FULL) begin
			range_mask = flash_pkg::RANGE_ALL;
		end else if (erase_q && blk_q == flash_pkg::BLK_HALF) begin
			range_mask = target_q[flash_pkg::HALF_BIT] ? flash_pkg::RANGE_UPPER
			                                           : flash_pkg::RANGE_LOWER;
		end
	end

	// a zero latch passes everything, any set bit over the target blocks it;
	// only a live select can violate, else a dropped select could never be set again
	assign violation = prot_seen_q && target_ok_q && (pgm_q || erase_q) &&
	                   (|(prot_latch_q & range_mask));
	// wait and stop starve the pump but leave the mode bits alone
	assign pump_ok   = high_voltage_enable_q && !wait_mode && !stop_mode;
	assign ctrl_wr   = wr && addr == flash_pkg::CTRL_ADDR;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_d         = state_q;
		pgm_d           = pgm_q;
		erase_d         = erase_q;
		margin_d        = margin_q;
		high_voltage_enable_d          = high_voltage_enable_q;
		blk_d           = blk_q;
		fdiv_d          = fdiv_q;
		prot_d          = prot_q;
		prot_latch_d    = prot_latch_q;
		prot_seen_d     = prot_seen_q;
		target_ok_d     = target_ok_q;
		target_d        = target_q;
		cnt_d           = cnt_q;
		issue_d         = 1'b0;
		issue_idx_d     = issue_idx_q;
		rdata_d         = rdata_q;
		rdata_valid_d   = 1'b0;
		hold_d          = hold_q;
		array_addr_d    = array_addr_q;
		array_wdata_d   = array_wdata_q;
		array_we_d      = 1'b0;
		array_re_d      = 1'b0;
		sel_rise        = 1'b0;
		pg.clr          = 1'b0;
		pg.wr_en        = 1'b0;
		pg.wr_idx       = addr[2:0];
		pg.wr_data      = wdata;
		pg.rd_idx       = cnt_q[2:0];

		// control register write
		if (ctrl_wr) begin
			// a write asking for both selects gets neither
			pgm_d    = wdata[flash_pkg::PGM_BIT] && !wdata[flash_pkg::ERASE_BIT];
			erase_d  = wdata[flash_pkg::ERASE_BIT] && !wdata[flash_pkg::PGM_BIT];
			// needs a select, a protect read and a latched target
			high_voltage_enable_d   = wdata[flash_pkg::HIGH_VOLTAGE_ENABLE_BIT] && (pgm_d || erase_d) &&
			           (pgm_d == pgm_q) && (erase_d == erase_q) &&
			           prot_seen_q && target_ok_q && !violation;
			// refused while high voltage is enabled or the same write asks for it
			margin_d = wdata[flash_pkg::MARGIN_BIT] && !high_voltage_enable_q &&
			           !wdata[flash_pkg::HIGH_VOLTAGE_ENABLE_BIT];
			blk_d    = wdata[flash_pkg::BLK_LO +: 2];
			fdiv_d   = wdata[flash_pkg::FDIV_LO +: 2];
			sel_rise = (pgm_d && !pgm_q) || (erase_d && !erase_q);
		end

		// a fresh select starts a new sequence with a clean page
		if (sel_rise) begin
			prot_seen_d = 1'b0;
			target_ok_d = 1'b0;
			pg.clr      = 1'b1;
		end

		// protect register read latches the value for the check
		if (rd && addr == flash_pkg::PROT_ADDR) begin
			prot_latch_d = prot_q;
			prot_seen_d  = pgm_q || erase_q;
		end

		// protect register itself changes only under elevated pin voltage
		if (wr && addr == flash_pkg::PROT_ADDR && vhi_q) begin
			if (pgm_q) begin
				prot_d = prot_q | wdata;
			end else if (erase_q) begin
				prot_d = flash_pkg::PROT_RESET;
			end
		end

		// array writes in program or erase mode with high voltage off are captured, else ignored
		if (wr && flash_pkg::is_array(addr) && (pgm_q || erase_q) && !high_voltage_enable_q) begin
			target_d    = {addr[15:3], 3'h0};
			target_ok_d = 1'b1;
			pg.wr_en    = pgm_q;
		end

		// overlap with a protected block drops the selects and high voltage
		if (violation) begin
			pgm_d  = 1'b0;
			erase_d = 1'b0;
			high_voltage_enable_d = 1'b0;
		end

		// register reads answer in the next cycle
		if (rd && addr == flash_pkg::CTRL_ADDR) begin
			rdata_d       = {fdiv_q, blk_q, high_voltage_enable_q, margin_q, erase_q, pgm_q};
			rdata_valid_d = 1'b1;
		end else if (rd && addr == flash_pkg::PROT_ADDR) begin
			rdata_d       = prot_q;
			rdata_valid_d = 1'b1;
		end else if (rd && !(flash_pkg::is_array(addr) && state_q == flash_pkg::st_idle)) begin
			rdata_d       = '0;
			rdata_valid_d = 1'b1;
		end

		case (state_q)
			flash_pkg::st_idle: begin
				if (rd && flash_pkg::is_array(addr)) begin
					// every margin read restarts the stretch counter
					array_addr_d = addr;
					array_re_d   = 1'b1;
					hold_d       = 1'b1;
					cnt_d        = margin_q ? flash_pkg::READ_LAT + flash_pkg::MARGIN_EXTRA
					                        : flash_pkg::READ_LAT;
					state_d      = flash_pkg::st_read;
				end else if (high_voltage_enable_d && !high_voltage_enable_q && pgm_d) begin
					cnt_d   = '0;
					state_d = flash_pkg::st_burn;
				end
			end
			flash_pkg::st_read: begin
				// the cpu is held but the watchdog clock is not touched
				if (cnt_q == '0) begin
					rdata_d       = array_rdata;
					rdata_valid_d = 1'b1;
					hold_d        = 1'b0;
					state_d       = flash_pkg::st_idle;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			flash_pkg::st_burn: begin
				// page bytes go out one per cycle while the pump runs
				if (!high_voltage_enable_q) begin
					state_d = flash_pkg::st_idle;
				end else if (pump_ok && cnt_q != flash_pkg::BURN_LAST) begin
					issue_d     = 1'b1;
					issue_idx_d = cnt_q[2:0];
					cnt_d       = cnt_q + 4'h1;
				end else if (cnt_q == flash_pkg::BURN_LAST && !issue_q) begin
					state_d = flash_pkg::st_idle;
				end
			end
			default: begin
				state_d = flash_pkg::st_idle;
			end
		endcase

		// buffer data arrive one cycle after their index
		if (issue_q) begin
			array_we_d    = 1'b1;
			array_addr_d  = {target_q[15:3], issue_idx_q};
			array_wdata_d = pg.rd_data;
		end
	end

	// array mode lines follow the control bits
	assign array_margin_d  = margin_q;
	assign array_erase_d   = erase_q && pump_ok;
	assign pump_on_d       = pump_ok;
	// standby only from read mode; an active program keeps its state
	assign array_standby_d = stop_mode && !pgm_q && !erase_q;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q         <= flash_pkg::st_idle;
			pgm_q           <= flash_pkg::CTRL_RESET[flash_pkg::PGM_BIT];
			erase_q         <= flash_pkg::CTRL_RESET[flash_pkg::ERASE_BIT];
			margin_q        <= flash_pkg::CTRL_RESET[flash_pkg::MARGIN_BIT];
			high_voltage_enable_q          <= flash_pkg::CTRL_RESET[flash_pkg::HIGH_VOLTAGE_ENABLE_BIT];
			blk_q           <= flash_pkg::CTRL_RESET[flash_pkg::BLK_LO +: 2];
			fdiv_q          <= flash_pkg::CTRL_RESET[flash_pkg::FDIV_LO +: 2];
			prot_q          <= flash_pkg::PROT_RESET;
			prot_latch_q    <= flash_pkg::PROT_RESET;
			prot_seen_q     <= 1'b0;
			target_ok_q     <= 1'b0;
			target_q        <= '0;
			cnt_q           <= '0;
			issue_q         <= 1'b0;
			issue_idx_q     <= '0;
			rdata_q         <= '0;
			rdata_valid_q   <= 1'b0;
			hold_q          <= 1'b0;
			array_addr_q    <= '0;
			array_wdata_q   <= '0;
			array_we_q      <= 1'b0;
			array_re_q      <= 1'b0;
			array_margin_q  <= 1'b0;
			array_erase_q   <= 1'b0;
			array_blk_q     <= '0;
			array_standby_q <= 1'b0;
			pump_on_q       <= 1'b0;
		end else begin
			state_q         <= state_d;
			pgm_q           <= pgm_d;
			erase_q         <= erase_d;
			margin_q        <= margin_d;
			high_voltage_enable_q          <= high_voltage_enable_d;
			blk_q           <= blk_d;
			fdiv_q          <= fdiv_d;
			prot_q          <= prot_d;
			prot_latch_q    <= prot_latch_d;
			prot_seen_q     <= prot_seen_d;
			target_ok_q     <= target_ok_d;
			target_q        <= target_d;
			cnt_q           <= cnt_d;
			issue_q         <= issue_d;
			issue_idx_q     <= issue_idx_d;
			rdata_q         <= rdata_d;
			rdata_valid_q   <= rdata_valid_d;
			hold_q          <= hold_d;
			array_addr_q    <= array_addr_d;
			array_wdata_q   <= array_wdata_d;
			array_we_q      <= array_we_d;
			array_re_q      <= array_re_d;
			array_margin_q  <= array_margin_d;
			array_erase_q   <= array_erase_d;
			array_blk_q     <= blk_q;
			array_standby_q <= array_standby_d;
			pump_on_q       <= pump_on_d;
		end
	end

	// fdiv is stored for software only; the pump divider lives elsewhere

endmodule : flash_program_margin_protect

// *** rtl/flash_pkg.sv ***
// constants, state and address map of the flash program / margin / protect controller
// assumes a 16-bit cpu address space, byte data, one bus clock mclk

package flash_pkg;

	localparam int          ADDR_W       = 16;
	localparam int          DATA_W       = 8;
	localparam int          PAGE_BYTES   = 8;
	localparam int          IDX_W        = 3;

	// register addresses
	localparam logic [15:0] CTRL_ADDR    = 16'hFE11;
	localparam logic [15:0] PROT_ADDR    = 16'hFF81;

	// control register fields
	localparam int          PGM_BIT      = 0;
	localparam int          ERASE_BIT    = 1;
	localparam int          MARGIN_BIT   = 2;
	localparam int          HIGH_VOLTAGE_ENABLE_BIT     = 3;
	localparam int          BLK_LO       = 4;
	localparam int          FDIV_LO      = 6;

	// reset values
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  PROT_RESET   = 8'h00;

	// access timing in bus cycles
	localparam logic [3:0]  READ_LAT     = 4'h1;
	localparam logic [3:0]  MARGIN_EXTRA = 4'h8;
	localparam logic [3:0]  BURN_LAST    = 4'h8;

	// user array windows
	localparam logic [15:0] WIN0_LO      = 16'h0450;
	localparam logic [15:0] WIN0_HI      = 16'h04FF;
	localparam logic [15:0] WIN1_LO      = 16'h0580;
	localparam logic [15:0] WIN1_HI      = 16'h05FF;
	localparam logic [15:0] WIN2_LO      = 16'h0E00;
	localparam logic [15:0] WIN2_HI      = 16'h7FFF;

	// protect ranges: address bits 14..12 pick one of eight ranges
	localparam int          RANGE_LO     = 12;
	localparam int          HALF_BIT     = 14;
	localparam logic [7:0]  RANGE_ONE    = 8'h01;
	localparam logic [7:0]  RANGE_ALL    = 8'hFF;
	localparam logic [7:0]  RANGE_UPPER  = 8'hF0;
	localparam logic [7:0]  RANGE_LOWER  = 8'h0F;
	localparam logic [1:0]  BLK_FULL     = 2'h0;
	localparam logic [1:0]  BLK_HALF     = 2'h1;

	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_read = 3'h2,
		st_burn = 3'h4
	} seq_state_type;

	function automatic logic is_array(input logic [15:0] a);
		is_array = (a >= WIN0_LO && a <= WIN0_HI) || (a >= WIN1_LO && a <= WIN1_HI) ||
		           (a >= WIN2_LO && a <= WIN2_HI);
	endfunction : is_array

endpackage : flash_pkg

// *** rtl/page_if.sv ***
// carrier between the sequencer and its page store
// assumes both ends sit on mclk
`timescale 1ns/1ns

interface page_if;
	logic       clr;
	logic       wr_en;
	logic [2:0] wr_idx;
	logic [7:0] wr_data;
	logic [2:0] rd_idx;
	logic [7:0] rd_data;

	modport ctrl  (output clr, output wr_en, output wr_idx, output wr_data,
	               output rd_idx, input rd_data);
	modport store (input clr, input wr_en, input wr_idx, input wr_data,
	               input rd_idx, output rd_data);
endinterface : page_if

// *** rtl/page_buffer.sv ***
// eight-byte page store that holds captured program data
// assumes clr and wr_en never matter in the same cycle beyond clr winning
`timescale 1ns/1ns

module page_buffer (
	// clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// sequencer side
	page_if.store     pg
);

	logic [7:0] mem_q [flash_pkg::PAGE_BYTES];
	logic [7:0] mem_d [flash_pkg::PAGE_BYTES];
	logic [7:0] rd_q;
	logic [7:0] rd_d;

	// ----------------------------------------------------------------
	// storage entries
	// ----------------------------------------------------------------
	for (genvar i = 0; i < flash_pkg::PAGE_BYTES; i++) begin : g_entry
		// bytes never written stay zero so they leave erased cells alone
		always_comb begin
			if (pg.clr) begin
				mem_d[i] = '0;
			end else if (pg.wr_en && pg.wr_idx == 3'(i)) begin
				mem_d[i] = pg.wr_data;
			end else begin
				mem_d[i] = mem_q[i];
			end
		end

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				mem_q[i] <= '0;
			end else begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	// registered read port, one cycle behind the index
	always_comb begin
		rd_d = mem_q[pg.rd_idx];
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign pg.rd_data = rd_q;

endmodule : page_buffer

// *** verif/flash_checker.sv ***
// concurrent checks on the ports of the flash sequencer top
// assumes it is bound into every flash_program_margin_protect instance
`timescale 1ns/1ns

module flash_checker (
	// clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// cpu side
	input wire logic [7:0]  rdata_q,
	input wire logic        rdata_valid_q,
	input wire logic        hold_q,
	input wire logic        wait_mode,
	input wire logic        stop_mode,
	// array and pump side
	input wire logic [15:0] array_addr_q,
	input wire logic        array_we_q,
	input wire logic        array_re_q,
	input wire logic        array_margin_q,
	input wire logic        array_standby_q,
	input wire logic        pump_on_q,
	input wire logic [7:0]  array_rdata
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// --------
	// read access shapes
	// --------
	// the hold covers the whole access so the cpu cannot strobe into it
	sequence normal_wait;
		hold_q [*2] ##1 (rdata_valid_q && !hold_q);
	endsequence
	sequence margin_wait;
		hold_q [*8] ##1 hold_q [*2] ##1 (rdata_valid_q && !hold_q);
	endsequence

	chk_normal_read: assert property (array_re_q && !array_margin_q |-> normal_wait)
		else $error("normal array read timing wrong");
	chk_margin_stretch: assert property (array_re_q && array_margin_q |-> margin_wait)
		else $error("margin read not stretched by eight");
	chk_normal_data: assert property (
		array_re_q && !array_margin_q |-> ##2 rdata_q == $past(array_rdata))
		else $error("normal read data not passed on");
	chk_margin_data: assert property (
		array_re_q && array_margin_q |-> ##10 rdata_q == $past(array_rdata))
		else $error("margin read data not passed on");

	// --------
	// pump, standby and programming
	// --------
	chk_pump_wait: assert property (wait_mode |=> !pump_on_q)
		else $error("pump running in wait");
	chk_pump_stop: assert property (stop_mode |=> !pump_on_q)
		else $error("pump running in stop");
	chk_pump_rise: assert property (
		$rose(pump_on_q) |-> !$past(wait_mode) && !$past(stop_mode))
		else $error("pump started in low power");
	chk_standby_stop: assert property (!stop_mode |=> !array_standby_q)
		else $error("standby without stop");
	chk_margin_pump: assert property (array_margin_q |-> !pump_on_q)
		else $error("margin set with high voltage on");
	chk_page_walk: assert property (
		array_we_q && $past(array_we_q) |-> array_addr_q[15:3] == $past(array_addr_q[15:3])
		&& array_addr_q[2:0] == $past(array_addr_q[2:0]) + 3'h1)
		else $error("program pulses leave the page");
endmodule : flash_checker

bind flash_program_margin_protect flash_checker flash_checker_inst (
	.mclk(mclk),
	.arst_n(arst_n),
	.rdata_q(rdata_q),
	.rdata_valid_q(rdata_valid_q),
	.hold_q(hold_q),
	.wait_mode(wait_mode),
	.stop_mode(stop_mode),
	.array_addr_q(array_addr_q),
	.array_we_q(array_we_q),
	.array_re_q(array_re_q),
	.array_margin_q(array_margin_q),
	.array_standby_q(array_standby_q),
	.pump_on_q(pump_on_q),
	.array_rdata(array_rdata)
);

// *** verif/flash_array_model.sv ***
// behavioural flash array seen from the sequencer's array pins
// assumes one-cycle program and read pulses on mclk
`timescale 1ns/1ns

module flash_array_model (
	// clock
	input  wire logic        mclk,
	// sequencer side
	input  wire logic [15:0] array_addr_q,
	input  wire logic [7:0]  array_wdata_q,
	input  wire logic        array_we_q,
	input  wire logic        array_re_q,
	input  wire logic        array_margin_q,
	output wire logic [7:0]  array_rdata
);
	logic [7:0] mem [logic [15:0]];
	logic [7:0] last = 8'h00;
	int         age = 100;
	int         span = 1;

	// --------
	// cells and sense output
	// --------
	// programming only sets bits; a cell never written reads erased
	always @(posedge mclk) begin
		if (array_we_q === 1'b1)
			mem[array_addr_q] = (mem.exists(array_addr_q) ? mem[array_addr_q] : 8'h00)
			                    | array_wdata_q;
		// nonblocking so the sequencer samples the sense output from before this edge
		if (array_re_q === 1'b1) begin
			last <= mem.exists(array_addr_q) ? mem[array_addr_q] : 8'h00;
			span <= array_margin_q ? 9 : 1;
			age  <= 0;
		end else if (age < 100)
			age <= age + 1;
	end

	// past the hold time the data go stale, so a late sample shows up
	assign array_rdata = (age < span) ? last : ~last;
endmodule : flash_array_model

// *** verif/test_flash_program_margin_protect.sv ***
// self-checking bench for the flash sequencer
// assumes the array model and the bound checker are compiled alongside
`timescale 1ns/1ns

module test_flash_program_margin_protect;
	localparam logic [15:0] CA   = flash_pkg::CTRL_ADDR;
	localparam logic [15:0] PA   = flash_pkg::PROT_ADDR;
	localparam logic [15:0] BASE = 16'h2008;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        wait_mode = 1'b0;
	logic        stop_mode = 1'b0;
	logic        elevated_pin_voltage = 1'b0;
	logic [7:0]  rdata_q, array_wdata_q, array_rdata, got;
	logic [15:0] array_addr_q;
	logic [1:0]  array_blk_q;
	logic        rdata_valid_q, hold_q, array_we_q, array_re_q, array_margin_q;
	logic        array_erase_q, array_standby_q, pump_on_q;
	int          n_fail = 0;
	int          num_checks = 0;
	int          seed = 32'hc62b;
	int          lat;
	logic [15:0] exp_addr [$];
	logic [7:0]  exp_data [$];
	logic [7:0]  model_mem [logic [15:0]];

	always #10 mclk = ~mclk;

	flash_program_margin_protect flash_program_margin_protect_inst (
		.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q), .hold_q(hold_q),
		.wait_mode(wait_mode), .stop_mode(stop_mode),
		.elevated_pin_voltage(elevated_pin_voltage), .array_addr_q(array_addr_q),
		.array_wdata_q(array_wdata_q), .array_we_q(array_we_q), .array_re_q(array_re_q),
		.array_margin_q(array_margin_q), .array_erase_q(array_erase_q),
		.array_blk_q(array_blk_q), .array_standby_q(array_standby_q),
		.pump_on_q(pump_on_q), .array_rdata(array_rdata));

	flash_array_model flash_array_model_inst (
		.mclk(mclk), .array_addr_q(array_addr_q), .array_wdata_q(array_wdata_q),
		.array_we_q(array_we_q), .array_re_q(array_re_q),
		.array_margin_q(array_margin_q), .array_rdata(array_rdata));

	// --------
	// reporting and compares
	// --------
	task automatic stop_test;
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic cmp_val(input logic [15:0] g, input logic [15:0] e, input string what);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask : cmp_val

	task automatic cmp_int(input int g, input int e, input string what);
		num_checks++;
		if (g != e) begin
			n_fail++;
			$display("MISMATCH %0t %s got %0d exp %0d", $time, what, g, e);
		end
	endtask : cmp_int

	// --------
	// bus master: one-cycle strobes launched just after a rising edge
	// --------
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	// waits out hold_q by polling the answer, bounded so a lost answer ends the run
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d, output int n);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		n = 1;
		#1;
		while (rdata_valid_q !== 1'b1 && n < 40) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 40) begin
			n_fail++;
			stop_test();
		end
		d = rdata_q;
	endtask : rd_reg

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input int n);
		logic [7:0] d;
		int         l;
		rd_reg(a, d, l);
		cmp_val({8'h00, d}, {8'h00, e}, "read data");
		cmp_int(l, n, "read latency");
	endtask : rd_chk

	task automatic flags_after(input logic pump, input logic standby);
		repeat (2) @(posedge mclk);
		#1;
		cmp_val({15'h0000, pump_on_q}, {15'h0000, pump}, "pump");
		cmp_val({15'h0000, array_standby_q}, {15'h0000, standby}, "standby");
	endtask : flags_after

	// program pulses must match the captured page, byte by byte in order
	always @(negedge mclk) begin
		if (arst_n && array_we_q === 1'b1) begin
			if (exp_addr.size() == 0)
				cmp_int(1, 0, "extra program pulse");
			else begin
				cmp_val(array_addr_q, exp_addr.pop_front(), "program address");
				cmp_val({8'h00, array_wdata_q}, {8'h00, exp_data.pop_front()}, "data");
			end
		end
	end

	initial begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		stop_test();
	end

	// --------
	// main sequence
	// --------
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		rd_chk(16'h0450, 8'h00, 3);
		rd_chk(CA, flash_pkg::CTRL_RESET, 1);
		wr_reg(CA, 8'h01);
		rd_chk(CA, 8'h01, 1);
		rd_chk(PA, flash_pkg::PROT_RESET, 1);
		for (int i = 0; i < 8; i++) begin
			got = 8'($random(seed));
			wr_reg(BASE | 16'(i), got);
			exp_addr.push_back(BASE | 16'(i));
			exp_data.push_back(got);
			model_mem[BASE | 16'(i)] = got;
			if (i == 3)
				rd_chk(16'h0200, 8'h00, 1);
		end
		wr_reg(CA, 8'h09);
		rd_chk(CA, 8'h09, 1);
		repeat (20) @(posedge mclk);
		wr_reg(CA, 8'h0D);
		rd_reg(CA, got, lat);
		cmp_val({15'h0000, got[2]}, 16'h0000, "margin with high voltage");
		wr_reg(CA, 8'h01);
		cmp_int(exp_addr.size(), 0, "page bytes left unprogrammed");
		wr_reg(CA, 8'h05);
		wr_reg(CA, 8'h04);
		for (int i = 0; i < 8; i++)
			rd_chk(BASE | 16'(i), model_mem[BASE | 16'(i)], 11);
		wr_reg(CA, 8'h00);
		@(posedge mclk);
		stop_mode <= 1'b1;
		flags_after(1'b0, 1'b1);
		@(posedge mclk);
		stop_mode <= 1'b0;
		wr_reg(CA, 8'h03);
		rd_chk(CA, 8'h00, 1);
		wr_reg(CA, 8'h01);
		wr_reg(16'h2010, 8'hA5);
		wr_reg(CA, 8'h09);
		rd_chk(CA, 8'h01, 1);
		wr_reg(CA, 8'h00);
		wr_reg(CA, 8'h01);
		wr_reg(PA, 8'h04);
		rd_chk(PA, 8'h00, 1);
		wr_reg(CA, 8'h00);
		@(posedge mclk);
		elevated_pin_voltage <= 1'b1;
		wr_reg(CA, 8'h01);
		wr_reg(PA, 8'h04);
		wr_reg(CA, 8'h00);
		@(posedge mclk);
		elevated_pin_voltage <= 1'b0;
		wr_reg(CA, 8'h01);
		rd_chk(PA, 8'h04, 1);
		wr_reg(16'h2040, 8'h5A);
		rd_chk(CA, 8'h00, 1);
		wr_reg(CA, 8'h01);
		rd_chk(PA, 8'h04, 1);
		wr_reg(16'h3040, 8'h5A);
		rd_chk(CA, 8'h01, 1);
		wr_reg(CA, 8'h00);
		// low power with high voltage on halts the burn; each pass leaves it with a reset
		for (int m = 0; m < 2; m++) begin
			wr_reg(CA, 8'h01);
			rd_reg(PA, got, lat);
			for (int i = 0; i < 8; i++) begin
				got = 8'($random(seed));
				wr_reg(16'h3040 | 16'(i), got);
				exp_addr.push_back(16'h3040 | 16'(i));
				exp_data.push_back(got);
			end
			wr_reg(CA, 8'h09);
			@(posedge mclk);
			wait_mode <= (m == 0);
			stop_mode <= (m == 1);
			flags_after(1'b0, 1'b0);
			rd_chk(CA, 8'h09, 1);
			cmp_int(exp_addr.size(), 7, "burn went on in low power");
			arst_n <= 1'b0;
			repeat (4) @(posedge mclk);
			wait_mode <= 1'b0;
			stop_mode <= 1'b0;
			arst_n <= 1'b1;
			exp_addr.delete();
			exp_data.delete();
			rd_chk(CA, flash_pkg::CTRL_RESET, 1);
		end
		for (int i = 0; i < 500; i++)
			rd_chk(BASE, model_mem[BASE], 3);
		stop_test();
	end
endmodule : test_flash_program_margin_protect
